// *** rtl/chop_ctrl_regs.vh ***
// constants for the h-bridge current chopping controller
// assumes a 200 mhz aclk and an axi4-lite register bus
`ifndef CHOP_CTRL_REGS_VH
`define CHOP_CTRL_REGS_VH
// register byte offsets
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_PERIOD 12'h008
`define REG_OCP_TIME 12'h00c
// control field positions
`define CTL_ENABLE 0
`define CTL_DIR 1
`define CTL_RESET_N 2
`define CTL_SLEEP_N 3
`define CTL_LEVEL_LSB 4
`define CTL_LEVEL_MSB 8
// reset values
`define CONTROL_RESET 32'h0000000c
`define PERIOD_RESET 16'h0fa0
`define OCP_TIME_RESET 16'h00c8
// timing
`define CLK_MHZ 200
`define BLANK_NS 3750
`define BLANK_CYCLES ((`BLANK_NS * `CLK_MHZ + 999) / 1000)
// decay codes
`define DECAY_SLOW 2'h0
`define DECAY_MIXED 2'h1
`define DECAY_FAST 2'h2
`endif

// *** rtl/hbridge_current_chop_control.v ***
// h-bridge current chopping control logic with an axi4-lite register slave
// assumes async comparator and fault indications and a tri-state decay pin sensed as two levels
`include "chop_ctrl_regs.vh"

// Summary of operation
// - bridge enable low: both outputs float
// - direction one: a high b low, else reverse
// - drive each period start, stop at threshold
// - sense times five against scaled reference
// - level code via sine table, top two full
// - table spans zero to full scale
// - decay pin: low slow, open mixed, high fast
// - fast decay reverses, then off near zero
// - slow decay turns both low sides on
// - mixed: fast then slow from 75 percent
// - comparator ignored during blanking after each drive start
// - blanking is also the minimum on-time
// - reset clears logic, disables bridge, ignores inputs except overtemperature, which still drives the fault output
// - sleep disables bridge, holds overcurrent count, ignores inputs
// - persistent current limit shuts bridge, fault low
// - overcurrent latch held until reset or power
// - overcurrent path separate from chopping sense
// - overtemperature disables bridge, auto resumes
// - undervoltage clears overcurrent latch and sequencer, registers kept, resumes on clear
module hbridge_current_chop_control (
   // clock, reset, clock enable
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // axi4-lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // asynchronous analog indications
   input wire chop_compare_in,
   input wire [3:0] fet_current_limit_in,
   input wire thermal_shutdown_in,
   input wire supply_undervoltage_lock_in,
   input wire decay_high_in,
   input wire decay_low_in,
   // bridge drive
   output reg bridge_a_high,
   output reg bridge_a_low,
   output reg bridge_b_high,
   output reg bridge_b_low,
   output reg [6:0] level_percent,
   output reg sleep_active,
   output reg fault_output_n_oe
);

   // ***********************************************************
   // input synchronisers
   // ***********************************************************
   localparam NSYNC = 8;
   reg [NSYNC-1:0] sync1;
   reg [NSYNC-1:0] sync2;
   reg [NSYNC-1:0] sync3;
   reg [NSYNC-1:0] clean;
   wire [NSYNC-1:0] raw_in = {decay_low_in, decay_high_in, supply_undervoltage_lock_in, thermal_shutdown_in,
      fet_current_limit_in};
   wire chop_hit;
   // three stages, accept change when second and third agree
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge aclk) begin
            if (!aresetn) begin
               sync1[gi] <= 1'b0;
               sync2[gi] <= 1'b0;
               sync3[gi] <= 1'b0;
               clean[gi] <= 1'b0;
            end else if (clk_en) begin
               sync1[gi] <= raw_in[gi];
               sync2[gi] <= sync1[gi];
               sync3[gi] <= sync2[gi];
               if (sync2[gi] == sync3[gi])
                  clean[gi] <= sync3[gi];
            end
         end
      end
   endgenerate
   reg cmp1, cmp2, cmp3, cmp_clean;
   // comparator: sense*5 vs scaled reference, done in the analog front end
   always @(posedge aclk) begin
      if (!aresetn) begin
         cmp1 <= 1'b0;
         cmp2 <= 1'b0;
         cmp3 <= 1'b0;
         cmp_clean <= 1'b0;
      end else if (clk_en) begin
         cmp1 <= chop_compare_in;
         cmp2 <= cmp1;
         cmp3 <= cmp2;
         if (cmp2 == cmp3)
            cmp_clean <= cmp3;
      end
   end
   assign chop_hit = cmp_clean;
   wire any_limit = |clean[3:0];
   wire hot = clean[4];
   wire supply_undervoltage_lock = clean[5];

   // ***********************************************************
   // register file
   // ***********************************************************
   reg [31:0] control;
   reg [15:0] period_cycles;
   reg [15:0] ocp_cycles;
   reg aw_held, w_held;
   reg [11:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg ocp_latched;
   reg [1:0] decay_mode;
   reg [2:0] phase_state;
   wire sw_reset_n = control[`CTL_RESET_N];
   wire sw_sleep_n = control[`CTL_SLEEP_N];
   wire [4:0] level_code = control[`CTL_LEVEL_MSB:`CTL_LEVEL_LSB];
   wire logic_run = sw_reset_n & sw_sleep_n & ~supply_undervoltage_lock;
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire wr_ok = (aw_addr == `REG_CONTROL) | (aw_addr == `REG_PERIOD) | (aw_addr == `REG_OCP_TIME);
   // byte-lane merge
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (st[k])
               merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction
   wire [31:0] next_control = merge(control, w_data, w_strb);
   wire [31:0] next_period = merge({16'h0000, period_cycles}, w_data, w_strb);
   wire [31:0] next_ocp = merge({16'h0000, ocp_cycles}, w_data, w_strb);
   // write channel capture and commit
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         control <= `CONTROL_RESET;
         period_cycles <= `PERIOD_RESET;
         ocp_cycles <= `OCP_TIME_RESET;
      end else if (clk_en) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'h0};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
            if (aw_addr == `REG_CONTROL)
               control <= {23'h000000, next_control[8:0]};
            if (aw_addr == `REG_PERIOD)
               period_cycles <= next_period[15:0];
            if (aw_addr == `REG_OCP_TIME)
               ocp_cycles <= next_ocp[15:0];
         end else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
   // read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (clk_en) begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[11:2], 2'h0})
               `REG_CONTROL: s_axi_rdata <= control;
               `REG_STATUS: s_axi_rdata <= {20'h00000, phase_state, decay_mode, chop_hit, supply_undervoltage_lock, hot,
                  ocp_latched, ~fault_output_n_oe, sleep_active, logic_run};
               `REG_PERIOD: s_axi_rdata <= {16'h0000, period_cycles};
               `REG_OCP_TIME: s_axi_rdata <= {16'h0000, ocp_cycles};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ***********************************************************
   // level table and decay decode
   // ***********************************************************
   // relative current in percent of full scale
   always @(posedge aclk) begin
      if (!aresetn)
         level_percent <= 7'h00;
      else if (clk_en & logic_run) begin
         case (level_code)
            5'h00: level_percent <= 7'd0;  5'h01: level_percent <= 7'd5;
            5'h02: level_percent <= 7'd10; 5'h03: level_percent <= 7'd15;
            5'h04: level_percent <= 7'd20; 5'h05: level_percent <= 7'd24;
            5'h06: level_percent <= 7'd29; 5'h07: level_percent <= 7'd34;
            5'h08: level_percent <= 7'd38; 5'h09: level_percent <= 7'd43;
            5'h0a: level_percent <= 7'd47; 5'h0b: level_percent <= 7'd51;
            5'h0c: level_percent <= 7'd56; 5'h0d: level_percent <= 7'd60;
            5'h0e: level_percent <= 7'd63; 5'h0f: level_percent <= 7'd67;
            5'h10: level_percent <= 7'd71; 5'h11: level_percent <= 7'd74;
            5'h12: level_percent <= 7'd77; 5'h13: level_percent <= 7'd80;
            5'h14: level_percent <= 7'd83; 5'h15: level_percent <= 7'd86;
            5'h16: level_percent <= 7'd88; 5'h17: level_percent <= 7'd90;
            5'h18: level_percent <= 7'd92; 5'h19: level_percent <= 7'd94;
            5'h1a: level_percent <= 7'd96; 5'h1b: level_percent <= 7'd97;
            5'h1c: level_percent <= 7'd98; 5'h1d: level_percent <= 7'd99;
            default: level_percent <= 7'd100;
         endcase
      end
   end
   // tri-state decay pin sensed as two comparators
   always @(posedge aclk) begin
      if (!aresetn)
         decay_mode <= `DECAY_SLOW;
      else if (clk_en & logic_run) begin
         if (clean[6])
            decay_mode <= `DECAY_FAST;
         else if (clean[7])
            decay_mode <= `DECAY_SLOW;
         else
            decay_mode <= `DECAY_MIXED;
      end
   end

   // ***********************************************************
   // protection
   // ***********************************************************
   reg [15:0] ocp_count;
   // qualify persistent current limit, latch until reset or power loss
   always @(posedge aclk) begin
      if (!aresetn) begin
         ocp_count <= 16'h0000;
         ocp_latched <= 1'b0;
      end else if (clk_en) begin
         if (!sw_reset_n | supply_undervoltage_lock) begin
            ocp_count <= 16'h0000;
            ocp_latched <= 1'b0;
         end else if (sw_sleep_n) begin
            if (any_limit) begin
               if (ocp_count >= ocp_cycles)
                  ocp_latched <= 1'b1;
               else
                  ocp_count <= ocp_count + 16'h0001;
            end else
               ocp_count <= 16'h0000;
         end
      end
   end
   wire fault = ocp_latched | hot;
   wire bridge_ok = logic_run & control[`CTL_ENABLE] & ~fault;

   // ***********************************************************
   // pwm chopping sequencer
   // ***********************************************************
   localparam ST_OFF = 3'h0;
   localparam ST_DRIVE = 3'h1;
   localparam ST_FAST = 3'h2;
   localparam ST_SLOW = 3'h3;
   localparam ST_IDLE = 3'h4;
   localparam [31:0] BLANK_WIDE = `BLANK_CYCLES;
   localparam [15:0] BLANK = BLANK_WIDE[15:0];
   reg [15:0] pwm_count;
   reg [15:0] on_count;
   wire [17:0] period_x3 = {2'h0, period_cycles} + {1'b0, period_cycles, 1'b0};
   wire [15:0] mix_point = period_x3[17:2]; // 75 percent of period
   wire period_end = (pwm_count >= period_cycles - 16'h0001);
   wire blank_done = (on_count >= BLANK);
   // fast decay ends when the sense drops, taken as current near zero
   always @(posedge aclk) begin
      if (!aresetn) begin
         phase_state <= ST_OFF;
         pwm_count <= 16'h0000;
         on_count <= 16'h0000;
      end else if (clk_en) begin
         if (!bridge_ok) begin
            phase_state <= ST_OFF;
            pwm_count <= 16'h0000;
            on_count <= 16'h0000;
         end else if (period_end | (phase_state == ST_OFF)) begin
            phase_state <= ST_DRIVE;
            pwm_count <= 16'h0000;
            on_count <= 16'h0000;
         end else begin
            pwm_count <= pwm_count + 16'h0001;
            case (phase_state)
               ST_DRIVE: begin
                  on_count <= on_count + 16'h0001;
                  if (blank_done & chop_hit) begin
                     if (decay_mode == `DECAY_SLOW)
                        phase_state <= ST_SLOW;
                     else if (decay_mode == `DECAY_MIXED & pwm_count >= mix_point)
                        phase_state <= ST_SLOW;
                     else
                        phase_state <= ST_FAST;
                  end
               end
               ST_FAST: begin
                  if (decay_mode == `DECAY_MIXED & pwm_count >= mix_point)
                     phase_state <= ST_SLOW;
                  else if (!chop_hit)
                     phase_state <= ST_IDLE;
               end
               ST_SLOW: phase_state <= ST_SLOW;
               // mixed decay waits off until the slow part of the period
               ST_IDLE: begin
                  if (decay_mode == `DECAY_MIXED & pwm_count >= mix_point)
                     phase_state <= ST_SLOW;
               end
               default: phase_state <= ST_OFF;
            endcase
         end
      end
   end

   // ***********************************************************
   // gate outputs
   // ***********************************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         bridge_a_high <= 1'b0;
         bridge_a_low <= 1'b0;
         bridge_b_high <= 1'b0;
         bridge_b_low <= 1'b0;
         sleep_active <= 1'b0;
         fault_output_n_oe <= 1'b0;
      end else if (clk_en) begin
         sleep_active <= ~sw_sleep_n;
         fault_output_n_oe <= fault & sw_sleep_n & ~supply_undervoltage_lock;
         case (phase_state)
            ST_DRIVE: begin
               bridge_a_high <= control[`CTL_DIR];
               bridge_a_low <= ~control[`CTL_DIR];
               bridge_b_high <= ~control[`CTL_DIR];
               bridge_b_low <= control[`CTL_DIR];
            end
            ST_FAST: begin
               bridge_a_high <= ~control[`CTL_DIR];
               bridge_a_low <= control[`CTL_DIR];
               bridge_b_high <= control[`CTL_DIR];
               bridge_b_low <= ~control[`CTL_DIR];
            end
            ST_SLOW: begin
               bridge_a_high <= 1'b0;
               bridge_a_low <= 1'b1;
               bridge_b_high <= 1'b0;
               bridge_b_low <= 1'b1;
            end
            default: begin
               bridge_a_high <= 1'b0;
               bridge_a_low <= 1'b0;
               bridge_b_high <= 1'b0;
               bridge_b_low <= 1'b0;
            end
         endcase
         if (!bridge_ok) begin
            bridge_a_high <= 1'b0;
            bridge_a_low <= 1'b0;
            bridge_b_high <= 1'b0;
            bridge_b_low <= 1'b0;
         end
      end
   end

endmodule

// *** verification/chop_ctrl_monitor.sv ***
// port assertions for the chopping controller
// assumes one aclk domain, bound onto the top module
`include "chop_ctrl_regs.vh"
module chop_ctrl_monitor (
   // clock and control
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // bus handshakes
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   // analog indications
   input wire thermal_shutdown_in,
   input wire supply_undervoltage_lock_in,
   // bridge side
   input wire bridge_a_high,
   input wire bridge_a_low,
   input wire bridge_b_high,
   input wire bridge_b_low,
   input wire [6:0] level_percent,
   input wire sleep_active,
   input wire fault_output_n_oe
);
   // ***************
   // helpers
   // ***************
   wire fwd = bridge_a_high & bridge_b_low;
   wire off = ~(bridge_a_high | bridge_a_low | bridge_b_high | bridge_b_low);
   reg [15:0] on_cnt;
   // length of the running forward drive
   always @(posedge aclk) begin
      if (!aresetn || !fwd) on_cnt <= 16'h0000;
      else if (clk_en) on_cnt <= on_cnt + 16'h0001;
   end
   default clocking mon_clk @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> off && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
   a_no_shoot: assert property (!(bridge_a_high && bridge_a_low) && !(bridge_b_high && bridge_b_low))
      else $error("both gates of one leg on");
   a_blank_min: assert property (fwd ##1 (bridge_a_low && !bridge_a_high) |-> $past(on_cnt) >= `BLANK_CYCLES - 1)
      else $error("drive ended inside blanking");
   a_fault_off: assert property (fault_output_n_oe && $past(fault_output_n_oe) |-> off)
      else $error("bridge on while fault shown");
   a_hot_fault: assert property ((thermal_shutdown_in && clk_en && !sleep_active)[*8] |-> fault_output_n_oe)
      else $error("overtemperature not reported");
   a_supply_undervoltage_lock_off: assert property ((supply_undervoltage_lock_in && clk_en)[*8] |-> off)
      else $error("bridge on during undervoltage");
   a_sleep_off: assert property (sleep_active && $past(sleep_active) |-> off)
      else $error("bridge on in sleep");
   a_level_max: assert property (level_percent <= 7'h64)
      else $error("level above full scale");
   a_read_lat: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
      else $error("read data late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   c_slow: cover property (bridge_a_low && bridge_b_low);
   c_reverse: cover property (fwd ##1 bridge_a_low && bridge_b_high);
   c_fault: cover property ($rose(fault_output_n_oe));
endmodule
bind hbridge_current_chop_control chop_ctrl_monitor i_monitor (.*);

// *** verification/winding_model.sv ***
// winding and sense comparator seen by the bridge
// assumes gate enables high = fet on
module winding_model (
   // clock
   input wire aclk,
   // gate enables
   input wire a_high,
   input wire a_low,
   input wire b_high,
   input wire b_low,
   // reference and level scaling
   input wire [15:0] ref_level,
   input wire [6:0] level_percent,
   // comparator out
   output logic chop_compare_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************
   // current model
   // ***************
   int amps = 0;
   int mag;
   // drive ramps up, reverse drains fast, low sides drain slowly
   always @(posedge aclk) begin
      if (a_high && b_low) amps <= amps + ((amps < 0) ? 8 : 1);
      else if (a_low && b_high) amps <= amps - ((amps > 0) ? 8 : 1);
      else if (a_low && b_low) amps <= amps - ((amps > 0) ? 1 : (amps < 0) ? -1 : 0);
      else amps <= amps - ((amps > 7) ? 8 : (amps < -7) ? -8 : amps);
   end
   // five times sense against scaled reference
   assign mag = (amps < 0) ? -amps : amps;
   assign chop_compare_in = (5 * mag) >= (ref_level * level_percent / 100);
endmodule

// *** verification/hbridge_current_chop_control_tb.sv ***
// self-checking bench for the chopping controller
// assumes the winding model closes the sense loop
`include "chop_ctrl_regs.vh"
module hbridge_current_chop_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %0t %h vs %h", $time, g, e); end end
   // ***************
   // signals
   // ***************
   logic aclk = 0, aresetn = 0, clk_en = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, chop_compare_in, thermal_shutdown_in = 0;
   logic supply_undervoltage_lock_in = 0, decay_high_in = 0, decay_low_in = 1;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 61126;
   logic [3:0] s_axi_wstrb = 4'hf, fet_current_limit_in = 0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low, sleep_active, fault_output_n_oe;
   logic [6:0] level_percent;
   logic [65:0] rd_q[$], e;
   logic [1:0] wr_q[$];
   int fail_count = 0, n_tests = 0;
   logic [6:0] tbl[32] = '{0, 5, 10, 15, 20, 24, 29, 34, 38, 43, 47, 51, 56, 60, 63, 67,
      71, 74, 77, 80, 83, 86, 88, 90, 92, 94, 96, 97, 98, 99, 100, 100};
   wire [3:0] g = {bridge_a_high, bridge_a_low, bridge_b_high, bridge_b_low};
   hbridge_current_chop_control i_dut (.*);
   winding_model i_load (.aclk, .a_high(bridge_a_high), .a_low(bridge_a_low), .b_high(bridge_b_high),
      .b_low(bridge_b_low), .ref_level(16'h01f4), .level_percent, .chop_compare_in);
   // 200 mhz clock
   always #2.5 aclk = ~aclk;
   // ***************
   // helpers
   // ***************
   function automatic logic [31:0] ctl(input logic en, dir, input logic [4:0] lv, input logic [1:0] rs = 2'h3);
      return {23'h0, lv, rs, dir, en};
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w, b;
      @(posedge aclk);
      wr_q.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw = s_axi_awready;
         w = s_axi_wready;
         b = s_axi_bvalid;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!b);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r, input logic [31:0] m = '1);
      logic ar, rv;
      @(posedge aclk);
      rd_q.push_back({r, m, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar = s_axi_arready;
         rv = s_axi_rvalid;
         @(posedge aclk);
         if (ar) s_axi_arvalid <= 1'b0;
      end while (!rv);
      s_axi_rready <= 1'b0;
   endtask
   // wait for a gate pattern, then compare it
   task automatic wg(input logic [3:0] p);
      int n = 0;
      while (g !== p && n < 5000) begin
         @(negedge aclk);
         n++;
      end
      `CMP(g, p)
   endtask
   // set decay pin levels, wait for the next drive
   task automatic dk(input logic [1:0] d);
      @(posedge aclk) {decay_high_in, decay_low_in} <= d;
      wg(4'b1001);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // compare each bus answer with the oldest note
   always @(posedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         e[1:0] = wr_q.pop_front();
         `CMP(s_axi_bresp, e[1:0])
      end
      if (s_axi_rvalid && s_axi_rready) begin
         e = rd_q.pop_front();
         `CMP({s_axi_rresp, s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]})
      end
   end
   // watchdog
   initial begin
      #300us;
      fail_count++;
      stop_test;
   end
   // ***************
   // scenarios
   // ***************
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`REG_CONTROL, `CONTROL_RESET, 2'h0);
      rd(`REG_PERIOD, {16'h0, `PERIOD_RESET}, 2'h0);
      rd(`REG_OCP_TIME, {16'h0, `OCP_TIME_RESET}, 2'h0);
      rd(12'h010, 32'h0, 2'h2);
      wr(12'h010, 32'hffffffff, 2'h2);
      wr(`REG_PERIOD, 32'h7d0, 2'h0);
      wr(`REG_OCP_TIME, 32'h4, 2'h0);
      for (int i = 0; i < 32; i++) begin
         wr(`REG_CONTROL, ctl(0, 0, 5'(i)), 2'h0);
         repeat (3) @(negedge aclk);
         `CMP(level_percent, tbl[i])
      end
      wr(`REG_CONTROL, ctl(1, 1, 31), 2'h0);
      wg(4'b1001);
      wg(4'b0101);
      dk(2'b10);
      wg(4'b0110);
      wg(4'b0000);
      dk(2'b00);
      wg(4'b0110);
      wg(4'b0000);
      wg(4'b0101);
      for (int i = 0; i < 3; i++) begin
         seed = xs(seed);
         wr(`REG_CONTROL, ctl(0, seed[0], seed[8:4]), 2'h0);
         repeat (3) @(negedge aclk);
         `CMP(g, 4'b0000)
      end
      wr(`REG_CONTROL, ctl(1, 0, 31), 2'h0);
      wg(4'b0110);
      @(posedge aclk) thermal_shutdown_in <= 1'b1;
      repeat (12) @(negedge aclk);
      `CMP({fault_output_n_oe, g}, 5'h10)
      @(posedge aclk) thermal_shutdown_in <= 1'b0;
      wg(4'b0110);
      `CMP(fault_output_n_oe, 1'b0)
      @(posedge aclk) fet_current_limit_in <= 4'h4;
      repeat (20) @(negedge aclk);
      @(posedge aclk) fet_current_limit_in <= 4'h0;
      repeat (20) @(negedge aclk);
      `CMP({fault_output_n_oe, g}, 5'h10)
      rd(`REG_STATUS, 32'h8, 2'h0, 32'h8);
      wr(`REG_CONTROL, ctl(1, 0, 31, 2'h2), 2'h0);
      wr(`REG_CONTROL, ctl(1, 0, 31), 2'h0);
      wg(4'b0110);
      `CMP(fault_output_n_oe, 1'b0)
      @(posedge aclk) supply_undervoltage_lock_in <= 1'b1;
      repeat (12) @(negedge aclk);
      `CMP(g, 4'b0000)
      @(posedge aclk) supply_undervoltage_lock_in <= 1'b0;
      wr(`REG_CONTROL, ctl(1, 1, 31, 2'h1), 2'h0);
      repeat (4) @(negedge aclk);
      `CMP({sleep_active, g}, 5'h10)
      wr(`REG_CONTROL, ctl(1, 1, 31), 2'h0);
      wg(4'b1001);
      // clock enable low freezes the running drive
      @(posedge aclk) clk_en <= 1'b0;
      repeat (50) @(negedge aclk);
      `CMP(g, 4'b1001)
      @(posedge aclk) clk_en <= 1'b1;
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(negedge aclk);
      `CMP({sleep_active, fault_output_n_oe, g}, 6'h00)
      stop_test;
   end
endmodule
